// >>> hw/edge_irq_defines.svh
// edge_irq_defines.svh: offsets, widths, reset values and bus codes
// assumes inclusion by bare name from the package and the design modules
`ifndef EDGE_IRQ_DEFINES_SVH
`define EDGE_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define PORT_W 32
`define DATA_W 32
`define ADDR_W 4
`define STRB_W 4

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_IRQ_ENABLE 4'h8
`define OFS_EDGE_LATCH 4'hc

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IRQ_ENABLE_RST 32'h0000_0000
`define EDGE_LATCH_RST 32'h0000_0000
`define RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hw/edge_irq_pkg.sv
// edge_irq_pkg: shared types of the edge capture interrupt port
// assumes edge_irq_defines.svh is on the include path
`include "edge_irq_defines.svh"

package edge_irq_pkg;

  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`PORT_W-1:0] port_t;

  // one register write, gathered from the address and data channels
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    word_t data;
    logic [`STRB_W-1:0] strb;
  } wr_req_s;

  typedef enum logic [1:0] {
    resp_okay = `RESP_OKAY,
    resp_slverr = `RESP_SLVERR
  } axi_resp_e;

endpackage

// >>> hw/input_sync.sv
// input_sync: two-flop synchroniser, one pair per input bit
// assumes rst_n is already synchronous to clk on release
`timescale 1ns/100ps
`default_nettype none
`include "edge_irq_defines.svh"

module input_sync
  import edge_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire port_t pin,
  output var port_t synced
);

  port_t meta_q;

  for (genvar i = 0; i < `PORT_W; i++)
  begin : g_bit
    // meta_q feeds only the second flop
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_q[i] <= 1'b0;
        synced[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= pin[i];
        synced[i] <= meta_q[i];
      end
    end
  end

endmodule

`default_nettype wire

// >>> hw/edge_capture_bank.sv
// edge_capture_bank: per-bit rising edge detect and sticky capture
// assumes in_s is synchronous to clk; clr is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
`include "edge_irq_defines.svh"

module edge_capture_bank
  import edge_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire port_t in_s,
  input wire logic clr,
  output wire port_t rise,
  output var port_t cap_q
);

  port_t prev_q;
  port_t cap_d;

  for (genvar i = 0; i < `PORT_W; i++)
  begin : g_bit
    assign rise[i] = in_s[i] & ~prev_q[i];
    // a rise in the clearing cycle survives the clear
    assign cap_d[i] = rise[i] | (cap_q[i] & ~clr);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= `EDGE_LATCH_RST;
      cap_q <= `EDGE_LATCH_RST;
    end
    else
    begin
      prev_q <= in_s;
      cap_q <= cap_d;
    end
  end

endmodule

`default_nettype wire

// >>> hw/parallel_port_edge_irq.sv
// parallel_port_edge_irq: interrupt side of a parallel input port
// assumes an AXI4-Lite master on clk and pins asynchronous to clk
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "edge_irq_defines.svh"

module parallel_port_edge_irq
  import edge_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire port_t port_in,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire word_t s_axi_wdata,
  input wire logic [`STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output var word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------------
  port_t in_s;
  port_t rise;
  port_t latch_q;
  port_t enable_q;
  logic latch_clr;

  input_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(port_in),
    .synced(in_s)
  );

  edge_capture_bank u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(in_s),
    .clr(latch_clr),
    .rise(rise),
    .cap_q(latch_q)
  );

  // ----------------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------------
  // address and data may come in either order; both are held until the
  // write is done, so only one write is ever under way
  wr_req_s wr_q;
  logic have_aw_q;
  logic have_w_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic have_aw_d;
  logic have_w_d;
  logic bvalid_d;
  logic wr_enable_hit;
  logic wr_latch_hit;
  axi_resp_e bresp_d;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = have_aw_q & have_w_q & ~s_axi_bvalid;
  assign have_aw_d = (have_aw_q | aw_take) & ~wr_fire;
  assign have_w_d = (have_w_q | w_take) & ~wr_fire;
  assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign wr_enable_hit = {wr_q.addr[`ADDR_W-1:2], 2'b00} == `OFS_IRQ_ENABLE;
  assign wr_latch_hit = {wr_q.addr[`ADDR_W-1:2], 2'b00} == `OFS_EDGE_LATCH;
  assign bresp_d = (wr_enable_hit | wr_latch_hit) ? resp_okay : resp_slverr;
  assign latch_clr = wr_fire & wr_latch_hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        wr_q.addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wr_q.data <= s_axi_wdata;
        wr_q.strb <= s_axi_wstrb;
      end
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~have_aw_d & ~bvalid_d;
      s_axi_wready <= ~have_w_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_fire)
      begin
        s_axi_bresp <= bresp_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt enable register
  // ----------------------------------------------------------------------
  port_t enable_d;

  for (genvar b = 0; b < `STRB_W; b++)
  begin : g_lane
    assign enable_d[8*b +: 8] = (wr_fire & wr_enable_hit & wr_q.strb[b]) ?
                                wr_q.data[8*b +: 8] : enable_q[8*b +: 8];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q <= `IRQ_ENABLE_RST;
    end
    else
    begin
      enable_q <= enable_d;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  logic ar_take;
  logic rd_enable_hit;
  logic rd_latch_hit;
  word_t rdata_d;
  axi_resp_e rresp_d;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_enable_hit = {s_axi_araddr[`ADDR_W-1:2], 2'b00} == `OFS_IRQ_ENABLE;
  assign rd_latch_hit = {s_axi_araddr[`ADDR_W-1:2], 2'b00} == `OFS_EDGE_LATCH;
  // reading the latch leaves it intact; only a write clears it
  assign rdata_d = rd_latch_hit ? latch_q :
                   rd_enable_hit ? enable_q : `RDATA_RST;
  assign rresp_d = (rd_enable_hit | rd_latch_hit) ? resp_okay : resp_slverr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RDATA_RST;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
    else if (!s_axi_rvalid || s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------------
  // registered for a clean output; follows the latch by one cycle
  logic irq_d;

  assign irq_d = |(latch_q & enable_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  enable_write_a: assert property (
    wr_fire && wr_enable_hit && wr_q.strb == 4'hf |=> enable_q == $past(wr_q.data))
    else $error("enable register missed a full write");

  enable_hold_a: assert property (
    !(wr_fire && wr_enable_hit) |=> enable_q == $past(enable_q))
    else $error("enable register changed without a write");

  masked_quiet_a: assert property (
    (enable_q == 32'h0000_0000) [*2] |-> !irq)
    else $error("interrupt raised with every enable bit at zero");

  edge_sets_a: assert property (
    rise != 32'h0000_0000 |=> (latch_q & $past(rise)) == $past(rise))
    else $error("rising edge not captured");

  latch_sticky_a: assert property (
    !latch_clr |=> (latch_q & $past(latch_q)) == $past(latch_q))
    else $error("captured bit lost without a clear");

  latch_clear_a: assert property (
    latch_clr && rise == 32'h0000_0000 |=> latch_q == 32'h0000_0000 ##1 !irq)
    else $error("latch write did not clear bits and interrupt");

  key_read_a: assert property (
    ar_take && rd_latch_hit |=> s_axi_rvalid && s_axi_rdata == $past(latch_q))
    else $error("latch read returned the wrong value");

  irq_level_a: assert property (
    |(latch_q & enable_q) |=> irq ##0 $past(irq_d))
    else $error("interrupt missing while an enabled bit is latched");

  irq_cause_a: assert property (
    $rose(irq) |-> $past(|(latch_q & enable_q)))
    else $error("interrupt rose with no enabled latched bit");

endmodule

`default_nettype wire

// >>> test/irq_ctrl_model.sv
// irq_ctrl_model: interrupt controller seen from the port
// assumes a level request, synchronous to clk
`timescale 1ns/100ps
`default_nettype none

module irq_ctrl_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq,
  output var int rise_count
);
  logic irq_q;

  // counts requests; a level held high counts once
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_q <= 1'b0;
      rise_count <= 0;
    end
    else
    begin
      irq_q <= irq;
      if (irq && !irq_q)
        rise_count <= rise_count + 1;
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// testbench: register bus sequences against the edge capture port
// assumes the design package and defines are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench
  import edge_irq_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  port_t port_in = '0;
  logic [3:0] awaddr = '0;
  logic [3:0] araddr = '0;
  word_t wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  word_t rdata, d;
  int fail_count = 0;
  int n_checks = 0;
  int irq_rises;

  always #5 clk = ~clk;

  parallel_port_edge_irq DUT (.clk(clk), .rstn(rstn), .port_in(port_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  irq_ctrl_model intc (.clk(clk), .rstn(rstn), .irq(irq), .rise_count(irq_rises));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus tasks: valid and payload held until each own ready
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input word_t v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 50)
      begin
        fail_count++;
        close_out();
      end
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output word_t v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 50)
      begin
        fail_count++;
        close_out();
      end
    end while (!(rvalid && rready));
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h8, d, r);
    check(d, 32'h0000_0000);
    rd(4'hc, d, r);
    check(d, 32'h0000_0000);
    rd(4'h0, d, r);
    check(32'(r), 32'(resp_slverr));
    wr(4'h4, 32'hffff_ffff, r);
    check(32'(r), 32'(resp_slverr));
    wr(4'h8, 32'h0000_0005, r);
    check(32'(r), 32'(resp_okay));
    rd(4'h8, d, r);
    check(d, 32'h0000_0005);
    // two keys pressed, then released: capture must hold
    @(posedge clk) port_in <= 32'h0000_0003;
    repeat (6) @(posedge clk);
    check(32'(irq), 32'h0000_0001);
    rd(4'hc, d, r);
    check(d, 32'h0000_0003);
    port_in <= 32'h0000_0000;
    repeat (6) @(posedge clk);
    rd(4'hc, d, r);
    check(d, 32'h0000_0003);
    // clearing write with zero data still clears everything
    wr(4'hc, 32'h0000_0000, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    rd(4'hc, d, r);
    check(d, 32'h0000_0000);
    // masked bit captures but stays silent
    wr(4'h8, 32'h0000_0004, r);
    @(posedge clk) port_in <= 32'h0000_0001;
    repeat (6) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    rd(4'hc, d, r);
    check(d, 32'h0000_0001);
    port_in <= 32'h0000_0005;
    repeat (6) @(posedge clk);
    check(32'(irq), 32'h0000_0001);
    check(32'(irq_rises), 32'h0000_0002);
    // one byte lane only; then a clearing write with no lane enabled
    wstrb <= 4'h2;
    wr(4'h8, 32'hffff_ffff, r);
    rd(4'h8, d, r);
    check(d, 32'h0000_ff04);
    check(32'(r), 32'(resp_okay));
    wstrb <= 4'h0;
    wr(4'hc, 32'hffff_ffff, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    rd(4'hc, d, r);
    check(d, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
